// ---- shared/pfsa_pkg.sv ----
/*
  Package for the flash self-access controller: register indices, field
  positions, reset values and timing counts.
  Assumes a 20 MHz core clock and an 8-bit register port.
*/
`default_nettype none

package pfsa_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices
  localparam logic [2:0] ADDR_DATA_LOW  = 3'h0;
  localparam logic [2:0] ADDR_DATA_HIGH = 3'h1;
  localparam logic [2:0] ADDR_ADDR_LOW  = 3'h2;
  localparam logic [2:0] ADDR_ADDR_HIGH = 3'h3;
  localparam logic [2:0] ADDR_CTRL      = 3'h4;
  localparam logic [2:0] ADDR_UNLOCK    = 3'h5;

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int CTRL_RD_BIT   = 0;
  localparam int CTRL_WR_BIT   = 1;
  localparam int CTRL_WRITE_ENABLE_BIT_BIT = 2;
  localparam int CTRL_ERR_BIT  = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and reset values
  localparam int         DATA_W     = 14;
  localparam int         ADDR_W     = 10;
  localparam int         ROW_WORDS  = 4;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Unlock keys and timing
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
  localparam int CLK_MHZ       = 20;
  localparam int WRITE_TIME_US = 2000;
  localparam int WRITE_CYCLES  = WRITE_TIME_US * CLK_MHZ;

  typedef enum logic [1:0] {
    PFSA_IDLE,
    PFSA_READ,
    PFSA_ERASE,
    PFSA_PROG
  } pfsa_state_e;

endpackage

`default_nettype wire

// ---- hdl/pfsa_ctrl.sv ----
/*
  Flash program memory self-access controller: six byte registers give the
  CPU indirect single-word read and four-word row write with auto erase.
  Assumes a register port with read data one cycle after the read strobe,
  and a flash array port with one-cycle read and word program/row erase.
*/
// Behaviour
// - CPU reads and writes flash at any time, no special mode.
// - Flash reached only through six indirect registers.
// - Two data registers hold one 14-bit flash word.
// - Two address registers form a 10-bit word address.
// - Word addresses run from 0x000 to 0x3FF.
// - Read moves one word; write commits four words.
// - Row write erases the row first, then programs.
// - Internal timer sets write and erase duration.
// - Setting start bits starts operations; writing zero does nothing.
// - Hardware clears start bits when the operation completes.
// - Write runs only when write enable is set.
// - Write enable is clear after reset.
// - Unlock register stores nothing and reads zero.
// - Unlock register writes form the write unlock sequence.
// - Code protection does not block self-access.
// - Write protect field blocks writes to chosen blocks, never reads.
// - Code protection denies the external programmer access.
`timescale 1ns/1ps
`default_nettype none

module pfsa_ctrl
#(
  parameter int WRITE_CYCLES = pfsa_pkg::WRITE_CYCLES
)
(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // Register port
  input  wire logic [2:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  // Configuration
  input  wire logic [1:0]  write_protect_field_i,
  input  wire logic        code_protect_bit_i,
  // External programmer gate
  output logic             prog_access_ok_o,
  // Flash array port
  output logic [9:0]       fl_addr_o,
  output logic [13:0]      fl_wdata_o,
  output logic             fl_rd_o,
  output logic             fl_erase_o,
  output logic             fl_prog_o,
  input  wire logic [13:0] fl_rdata_i
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    pfsa_pkg::pfsa_state_e state;
    logic [7:0]  data_low;
    logic [5:0]  data_high;
    logic [7:0]  addr_low;
    logic [7:0]  addr_high;
    logic        rd_bit;
    logic        wr_bit;
    logic        write_enable_bit;
    logic        err;
    logic [1:0]  unlock;
    logic [1:0]  word_idx;
    logic [13:0] buf0;
    logic [13:0] buf1;
    logic [13:0] buf2;
    logic [31:0] timer;
    logic [7:0]  rdata;
    logic        cp_n;
    logic [9:0]  fl_addr;
    logic [13:0] fl_wdata;
    logic        fl_rd;
    logic        fl_erase;
    logic        fl_prog;
  } pfsa_st_s;

  pfsa_st_s st_ff;
  pfsa_st_s nxt_st;

  logic [9:0] waddr;
  logic       blocked;

  assign waddr = {st_ff.addr_high[1:0], st_ff.addr_low};

  // Block write protect, four 256-word blocks by field value
  always_comb
  begin
    unique case (st_ff.addr_high[1:0] >= ~write_protect_field_i)
      1'b1: blocked = (write_protect_field_i != 2'b00);
      default: blocked = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    nxt_st          = st_ff;
    nxt_st.rdata    = 8'h00;
    nxt_st.fl_rd    = 1'b0;
    nxt_st.fl_erase = 1'b0;
    nxt_st.fl_prog  = 1'b0;
    nxt_st.cp_n     = ~code_protect_bit_i;

    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        pfsa_pkg::ADDR_DATA_LOW:  nxt_st.rdata = st_ff.data_low;
        pfsa_pkg::ADDR_DATA_HIGH: nxt_st.rdata = {2'b00, st_ff.data_high};
        pfsa_pkg::ADDR_ADDR_LOW:  nxt_st.rdata = st_ff.addr_low;
        pfsa_pkg::ADDR_ADDR_HIGH: nxt_st.rdata = st_ff.addr_high;
        pfsa_pkg::ADDR_CTRL:      nxt_st.rdata = {4'h0, st_ff.err, st_ff.write_enable_bit,
                                                  st_ff.wr_bit, st_ff.rd_bit};
        default:                  nxt_st.rdata = 8'h00;
      endcase
    end

    if (reg_wr_i)
    begin
      unique case (reg_addr_i)
        pfsa_pkg::ADDR_DATA_LOW:  nxt_st.data_low  = reg_wdata_i;
        pfsa_pkg::ADDR_DATA_HIGH: nxt_st.data_high = reg_wdata_i[5:0];
        pfsa_pkg::ADDR_ADDR_LOW:  nxt_st.addr_low  = reg_wdata_i;
        pfsa_pkg::ADDR_ADDR_HIGH: nxt_st.addr_high = reg_wdata_i;
        pfsa_pkg::ADDR_CTRL:
        begin
          nxt_st.write_enable_bit = reg_wdata_i[pfsa_pkg::CTRL_WRITE_ENABLE_BIT_BIT];
          nxt_st.err  = st_ff.err & reg_wdata_i[pfsa_pkg::CTRL_ERR_BIT];
          if (reg_wdata_i[pfsa_pkg::CTRL_RD_BIT] && st_ff.state == pfsa_pkg::PFSA_IDLE)
            nxt_st.rd_bit = 1'b1;
          if (reg_wdata_i[pfsa_pkg::CTRL_WR_BIT] && st_ff.state == pfsa_pkg::PFSA_IDLE)
          begin
            if (st_ff.write_enable_bit && st_ff.unlock == 2'd2 && !blocked)
              nxt_st.wr_bit = 1'b1;
            else
              nxt_st.err = 1'b1;
          end
          nxt_st.unlock = 2'd0;
        end
        pfsa_pkg::ADDR_UNLOCK:
        begin
          if (reg_wdata_i == pfsa_pkg::UNLOCK_KEY1)
            nxt_st.unlock = 2'd1;
          else if (reg_wdata_i == pfsa_pkg::UNLOCK_KEY2 && st_ff.unlock == 2'd1)
            nxt_st.unlock = 2'd2;
          else
            nxt_st.unlock = 2'd0;
        end
        default: ;
      endcase
    end

    unique case (st_ff.state)
      pfsa_pkg::PFSA_IDLE:
      begin
        if (st_ff.rd_bit)
        begin
          nxt_st.state   = pfsa_pkg::PFSA_READ;
          nxt_st.fl_addr = waddr;
          nxt_st.fl_rd   = 1'b1;
        end
        else if (st_ff.wr_bit)
        begin
          unique case (st_ff.addr_low[1:0])
            2'd0: nxt_st.buf0 = {st_ff.data_high, st_ff.data_low};
            2'd1: nxt_st.buf1 = {st_ff.data_high, st_ff.data_low};
            2'd2: nxt_st.buf2 = {st_ff.data_high, st_ff.data_low};
            default:
            begin
              nxt_st.state    = pfsa_pkg::PFSA_ERASE;
              nxt_st.fl_addr  = {waddr[9:2], 2'b00};
              nxt_st.fl_erase = 1'b1;
              nxt_st.timer    = 32'(WRITE_CYCLES);
              nxt_st.word_idx = 2'd0;
            end
          endcase
          if (st_ff.addr_low[1:0] != 2'd3)
            nxt_st.wr_bit = 1'b0;
        end
      end
      pfsa_pkg::PFSA_READ:
      begin
        nxt_st.data_low  = fl_rdata_i[7:0];
        nxt_st.data_high = fl_rdata_i[13:8];
        nxt_st.rd_bit    = 1'b0;
        nxt_st.state     = pfsa_pkg::PFSA_IDLE;
      end
      pfsa_pkg::PFSA_ERASE, pfsa_pkg::PFSA_PROG:
      begin
        if (st_ff.timer != 32'd0)
          nxt_st.timer = st_ff.timer - 32'd1;
        else if (st_ff.state == pfsa_pkg::PFSA_ERASE
                 || st_ff.word_idx != 2'(pfsa_pkg::ROW_WORDS - 1))
        begin
          nxt_st.word_idx = (st_ff.state == pfsa_pkg::PFSA_ERASE) ? 2'd0
                            : st_ff.word_idx + 2'd1;
          nxt_st.state    = pfsa_pkg::PFSA_PROG;
          nxt_st.timer    = 32'(WRITE_CYCLES);
          nxt_st.fl_prog  = 1'b1;
          nxt_st.fl_addr  = {waddr[9:2], nxt_st.word_idx};
          unique case (nxt_st.word_idx)
            2'd0: nxt_st.fl_wdata = st_ff.buf0;
            2'd1: nxt_st.fl_wdata = st_ff.buf1;
            2'd2: nxt_st.fl_wdata = st_ff.buf2;
            default: nxt_st.fl_wdata = {st_ff.data_high, st_ff.data_low};
          endcase
        end
        else
        begin
          nxt_st.wr_bit = 1'b0;
          nxt_st.state  = pfsa_pkg::PFSA_IDLE;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata_o      = st_ff.rdata;
  assign prog_access_ok_o = st_ff.cp_n;
  assign fl_addr_o        = st_ff.fl_addr;
  assign fl_wdata_o       = st_ff.fl_wdata;
  assign fl_rd_o          = st_ff.fl_rd;
  assign fl_erase_o       = st_ff.fl_erase;
  assign fl_prog_o        = st_ff.fl_prog;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_unlock_zero;
    @(posedge core_clk_i) disable iff (rst_i)
    reg_rd_i && reg_addr_i == pfsa_pkg::ADDR_UNLOCK |=> reg_rdata_o == 8'h00;
  endproperty
  a_unlock_zero: assert property (p_unlock_zero) else $error("unlock read not zero");

  property p_read_done;
    @(posedge core_clk_i) disable iff (rst_i)
    st_ff.state == pfsa_pkg::PFSA_READ |=> !st_ff.rd_bit;
  endproperty
  a_read_done: assert property (p_read_done) else $error("read bit not cleared");

  property p_read_data;
    @(posedge core_clk_i) disable iff (rst_i)
    st_ff.state == pfsa_pkg::PFSA_READ
      |=> {st_ff.data_high, st_ff.data_low} == $past(fl_rdata_i);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read word not loaded");

  property p_wr_needs_en;
    @(posedge core_clk_i) disable iff (rst_i)
    $rose(st_ff.wr_bit) |-> $past(st_ff.write_enable_bit);
  endproperty
  a_wr_needs_en: assert property (p_wr_needs_en) else $error("write without enable");

  property p_no_abort;
    @(posedge core_clk_i) disable iff (rst_i)
    st_ff.state == pfsa_pkg::PFSA_PROG && st_ff.timer != 32'd0 |=> st_ff.wr_bit;
  endproperty
  a_no_abort: assert property (p_no_abort) else $error("write aborted");

  property p_erase_first;
    @(posedge core_clk_i) disable iff (rst_i)
    fl_erase_o |-> fl_addr_o[1:0] == 2'b00 && st_ff.state == pfsa_pkg::PFSA_ERASE;
  endproperty
  a_erase_first: assert property (p_erase_first) else $error("erase not row aligned");

  property p_timer;
    @(posedge core_clk_i) disable iff (rst_i)
    fl_prog_o |-> st_ff.timer == 32'(WRITE_CYCLES);
  endproperty
  a_timer: assert property (p_timer) else $error("timer not loaded");

  property p_prog_gate;
    @(posedge core_clk_i) disable iff (rst_i)
    code_protect_bit_i |=> !prog_access_ok_o;
  endproperty
  a_prog_gate: assert property (p_prog_gate) else $error("programmer not gated");

  property p_addr_range;
    @(posedge core_clk_i) disable iff (rst_i)
    fl_rd_o |-> fl_addr_o == $past(waddr);
  endproperty
  a_addr_range: assert property (p_addr_range) else $error("bad read address");

endmodule

`default_nettype wire

// ---- verification/pfsa_flash_model.sv ----
/*
  Behavioural flash array facing the self-access controller.
  Assumes one-cycle reads and pulse-driven row erase and word program.
*/
`timescale 1ns/1ps
`default_nettype none

module pfsa_flash_model
(
  // Clock
  input  wire logic        core_clk_i,
  // Array port
  input  wire logic [9:0]  fl_addr_i,
  input  wire logic [13:0] fl_wdata_i,
  input  wire logic        fl_rd_i,
  input  wire logic        fl_erase_i,
  input  wire logic        fl_prog_i,
  output logic      [13:0] fl_rdata_o
);
  logic [13:0] mem [1024];
  logic [13:0] junk;

  initial
  begin
    for (int i = 0; i < 1024; i++)
      mem[i] = 14'(i * 5);
    junk = 14'h2a5a;
  end

  // Word shown while the read pulse stands, junk otherwise
  assign fl_rdata_o = fl_rd_i ? mem[fl_addr_i] : junk;

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk_i)
  begin
    // Junk toggles so a mistimed sample shows up
    junk <= ~junk;
    if (fl_erase_i)
      for (int k = 0; k < 4; k++)
        mem[{fl_addr_i[9:2], 2'(k)}] <= 14'h3fff;
    // Programming only clears bits
    if (fl_prog_i)
      mem[fl_addr_i] <= mem[fl_addr_i] & fl_wdata_i;
  end
endmodule

`default_nettype wire

// ---- verification/pfsa_ctrl_tb_top.sv ----
/*
  Self-checking bench for the flash self-access controller.
  Assumes the flash model beside it and a 20 MHz core clock.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) \
  begin \
    n_compared++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("mismatch %s expected %h seen %h", nm, e, g); \
    end \
  end

module pfsa_ctrl_tb_top;
  localparam int WC = 8;
  logic        core_clk_i  = 1'b0;
  logic        rst_i       = 1'b1;
  logic [2:0]  reg_addr_i  = 3'h0;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        reg_wr_i    = 1'b0;
  logic        reg_rd_i    = 1'b0;
  logic [1:0]  wp          = 2'h0;
  logic        cp          = 1'b0;
  logic [7:0]  reg_rdata_o, v, lo;
  logic        prog_ok, fl_rd, fl_erase, fl_prog;
  logic [9:0]  fl_addr;
  logic [9:0]  ra;
  logic [13:0] fl_wdata, fl_rdata;
  logic [13:0] d [4];
  logic [13:0] e [4];
  int          error_cnt   = 0;
  int          n_compared  = 0;
  int          n_erase     = 0;
  int          n_prog      = 0;
  int          cyc         = 0;
  int          t_erase     = 0;
  int          t_prog      = 0;

  pfsa_ctrl #(.WRITE_CYCLES(WC)) u_pfsa_ctrl (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .write_protect_field_i(wp),
    .code_protect_bit_i(cp), .prog_access_ok_o(prog_ok), .fl_addr_o(fl_addr),
    .fl_wdata_o(fl_wdata), .fl_rd_o(fl_rd), .fl_erase_o(fl_erase), .fl_prog_o(fl_prog),
    .fl_rdata_i(fl_rdata));
  pfsa_flash_model u_pfsa_flash_model (.core_clk_i(core_clk_i), .fl_addr_i(fl_addr),
    .fl_wdata_i(fl_wdata), .fl_rd_i(fl_rd), .fl_erase_i(fl_erase), .fl_prog_i(fl_prog),
    .fl_rdata_o(fl_rdata));

  initial
  begin
    forever #25 core_clk_i = ~core_clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (fl_erase)
    begin
      n_erase++;
      t_erase = cyc;
    end
    if (fl_prog)
    begin
      if (n_prog % 4 == 0)
        t_prog = cyc;
      n_prog++;
    end
  end

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wr(input logic [2:0] ad, input logic [7:0] dt);
    @(posedge core_clk_i);
    reg_addr_i  <= ad;
    reg_wdata_i <= dt;
    reg_wr_i    <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] ad, output logic [7:0] dt);
    @(posedge core_clk_i);
    reg_addr_i <= ad;
    reg_rd_i   <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    dt = reg_rdata_o;
  endtask

  task automatic wait_clr(input logic [7:0] m);
    for (int i = 0; i < 200; i++)
    begin
      rd(pfsa_pkg::ADDR_CTRL, v);
      if ((v & m) == 8'h00)
        return;
    end
    `CHK("busy timeout", 1'b0, 1'b1)
    end_of_test();
  endtask

  task automatic set_addr(input logic [9:0] a);
    wr(pfsa_pkg::ADDR_ADDR_LOW, a[7:0]);
    wr(pfsa_pkg::ADDR_ADDR_HIGH, {6'($urandom), a[9:8]});
  endtask

  task automatic wr_word(input logic [9:0] a, input logic [13:0] dt, input logic [7:0] c);
    wr(pfsa_pkg::ADDR_DATA_LOW, dt[7:0]);
    wr(pfsa_pkg::ADDR_DATA_HIGH, {2'b00, dt[13:8]});
    set_addr(a);
    wr(pfsa_pkg::ADDR_UNLOCK, pfsa_pkg::UNLOCK_KEY1);
    wr(pfsa_pkg::ADDR_UNLOCK, pfsa_pkg::UNLOCK_KEY2);
    wr(pfsa_pkg::ADDR_CTRL, c);
  endtask

  task automatic write_row(input logic [9:0] a, input bit ok);
    int e0;
    int p0;
    e0 = n_erase;
    p0 = n_prog;
    wr(pfsa_pkg::ADDR_CTRL, 8'h04);
    for (int k = 0; k < 4; k++)
    begin
      d[k] = 14'($urandom);
      wr_word({a[9:2], 2'(k)}, d[k], 8'h06);
      if (k == 3 && ok)
      begin
        wr(pfsa_pkg::ADDR_CTRL, 8'h04);
        rd(pfsa_pkg::ADDR_CTRL, v);
        `CHK("wr bit held", 1'b1, v[1])
      end
      wait_clr(8'h02);
    end
    `CHK("erase count", e0 + int'(ok), n_erase)
    `CHK("prog count", p0 + 4 * int'(ok), n_prog)
    if (ok)
    begin
      `CHK("erase to prog", WC + 1, t_prog - t_erase)
      e = d;
    end
    rd(pfsa_pkg::ADDR_CTRL, v);
    `CHK("ctrl after write", ok ? 8'h04 : 8'h0c, v)
    wr(pfsa_pkg::ADDR_CTRL, 8'h04);
  endtask

  task automatic check_row(input logic [9:0] a);
    for (int k = 0; k < 4; k++)
    begin
      set_addr({a[9:2], 2'(k)});
      wr(pfsa_pkg::ADDR_CTRL, 8'h05);
      wait_clr(8'h01);
      rd(pfsa_pkg::ADDR_DATA_LOW, lo);
      rd(pfsa_pkg::ADDR_DATA_HIGH, v);
      `CHK("read word", e[k], {v[5:0], lo})
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h1e28));
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    for (int r = 0; r < 8; r++)
    begin
      rd(3'(r), v);
      `CHK("reset value", 8'h00, v)
    end
    wr(pfsa_pkg::ADDR_UNLOCK, pfsa_pkg::UNLOCK_KEY1);
    rd(pfsa_pkg::ADDR_UNLOCK, v);
    `CHK("unlock read", 8'h00, v)
    repeat (2) @(posedge core_clk_i);
    `CHK("prog access open", 1'b1, prog_ok)
    cp <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    `CHK("prog access shut", 1'b0, prog_ok)
    for (int i = 0; i < 5; i++)
    begin
      cp <= 1'($urandom);
      ra = (i % 2 == 0) ? 10'h3fc : 10'($urandom);
      write_row(ra, 1'b1);
      check_row(ra);
    end
    wr(pfsa_pkg::ADDR_CTRL, 8'h00);
    wr_word(10'h3ff, 14'h0000, 8'h02);
    rd(pfsa_pkg::ADDR_CTRL, v);
    `CHK("no write_enable_bit refused", 8'h08, v)
    wr(pfsa_pkg::ADDR_CTRL, 8'h04);
    wr(pfsa_pkg::ADDR_CTRL, 8'h06);
    rd(pfsa_pkg::ADDR_CTRL, v);
    `CHK("no unlock refused", 8'h0c, v)
    wr(pfsa_pkg::ADDR_CTRL, 8'h04);
    wp <= 2'b01;
    write_row(10'h3fc, 1'b0);
    check_row(10'h3fc);
    end_of_test();
  end
endmodule

`default_nettype wire
